// File: hdl/mbt_consts.svh
// byte positions, codes and limits for the modbus/tcp frame server
`ifndef MBT_CONSTS_SVH
`define MBT_CONSTS_SVH
`define HDR_LEN        9'h006
`define PROTO_ID       16'h0000
`define LEN_HI         8'h00
`define BCAST_ADDR     8'h00
`define MAX_STATION    8'hF7
`define ERR_BIT        8'h80
`define FC_READ_OUT    8'h01
`define FC_READ_IN     8'h02
`define FC_READ_HOLD   8'h03
`define FC_READ_INREG  8'h04
`define FC_WRITE_ONE   8'h05
`define FC_WRITE_REG   8'h06
`define FC_WRITE_OUTS  8'h0F
`define FC_WRITE_REGS  8'h10
`define EXC_FUNC       8'h01
`define EXC_ADDR       8'h02
`define EXC_VALUE      8'h03
`define COIL_ON        16'hFF00
`define COIL_OFF       16'h0000
`define MAX_REGS       16'h007D
`define FIXED_PLEN     8'h06
`define MULTI_PLEN     8'h07
`define MIN_LAST_POS   9'h007
`define POS_TID_HI     9'h000
`define POS_TID_LO     9'h001
`define POS_PID_HI     9'h002
`define POS_PID_LO     9'h003
`define POS_LEN_HI     9'h004
`define POS_LEN_LO     9'h005
`define POS_UNIT       9'h006
`define POS_FUNC       9'h007
`define POS_A_HI       9'h008
`define POS_A_LO       9'h009
`define POS_B_HI       9'h00A
`define POS_B_LO       9'h00B
`define POS_BITS_DATA  9'h009
`define CNT_SAT        9'h1FF
`endif

// File: hdl/mbt_pkg.sv
// types used by the modbus/tcp frame server top module
package mbt_pkg;
  typedef enum logic [0:0] {ST_IDLE, ST_SEND} srv_state_t;
  typedef enum logic [1:0] {RK_BITS, RK_REGS, RK_ECHO, RK_EXC} resp_kind_t;
endpackage

// File: hdl/query_if.sv
// parsed query handed from the frame parser to the server
`timescale 1ns/1ps
interface query_if;
  logic        valid;
  logic        accept;
  logic        frame_ok;
  logic [15:0] trans_id;
  logic [15:0] proto_id;
  logic [7:0]  unit;
  logic [7:0]  func;
  logic [15:0] word_a;
  logic [15:0] word_b;
  logic [7:0]  plen;
  modport parser (output valid, frame_ok, trans_id, proto_id, unit, func, word_a, word_b, plen,
                  input accept);
  modport server (input valid, frame_ok, trans_id, proto_id, unit, func, word_a, word_b, plen,
                  output accept);
endinterface

// File: hdl/frame_parser.sv
// collects one query frame from the byte stream and checks its prefix
`timescale 1ns/1ps
`include "mbt_consts.svh"
module frame_parser (
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  rx_valid,
  input  wire logic  [7:0] rx_data,
  input  wire logic  rx_last,
  output logic       rx_ready,
  query_if.parser    q
);
  logic [8:0] cnt;
  logic       pending;
  logic [7:0] len_hi;
  logic [7:0] len_lo;
  logic       take;
  logic [8:0] plen_full;

  // one frame is held until the server takes it; the sender is stalled meanwhile
  assign rx_ready  = !pending;
  assign take      = rx_valid && !pending;
  assign q.valid   = pending;
  assign plen_full = cnt - 9'h005;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= 9'h000;
    end else if (take) begin
      // saturation makes an overlong frame fail the length check
      cnt <= rx_last ? 9'h000 : ((cnt == `CNT_SAT) ? cnt : cnt + 9'h001);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q.trans_id <= 16'h0000;
      q.proto_id <= 16'h0000;
      len_hi     <= 8'h00;
      len_lo     <= 8'h00;
      q.unit     <= 8'h00;
      q.func     <= 8'h00;
      q.word_a   <= 16'h0000;
      q.word_b   <= 16'h0000;
    end else if (take) begin
      case (cnt)
        `POS_TID_HI: q.trans_id[15:8] <= rx_data;
        `POS_TID_LO: q.trans_id[7:0]  <= rx_data;
        `POS_PID_HI: q.proto_id[15:8] <= rx_data;
        `POS_PID_LO: q.proto_id[7:0]  <= rx_data;
        `POS_LEN_HI: len_hi           <= rx_data;
        `POS_LEN_LO: len_lo           <= rx_data;
        `POS_UNIT:   q.unit           <= rx_data;
        `POS_FUNC:   q.func           <= rx_data;
        `POS_A_HI:   q.word_a[15:8]   <= rx_data;
        `POS_A_LO:   q.word_a[7:0]    <= rx_data;
        `POS_B_HI:   q.word_b[15:8]   <= rx_data;
        `POS_B_LO:   q.word_b[7:0]    <= rx_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pending    <= 1'b0;
      q.frame_ok <= 1'b0;
      q.plen     <= 8'h00;
    end else if (take && rx_last) begin
      pending    <= 1'b1;
      q.plen     <= plen_full[7:0];
      q.frame_ok <= (cnt >= `MIN_LAST_POS) && (q.proto_id == `PROTO_ID)
                    && (len_hi == `LEN_HI)
                    && ({1'b0, len_lo} == plen_full);
    end else if (pending && q.accept) begin
      pending <= 1'b0;
    end
  end
endmodule

// File: hdl/bit_packer.sv
// picks eight channel bits for one response data byte, lowest channel in bit 0
`timescale 1ns/1ps
module bit_packer #(
  parameter int NUM_CH = 16
) (
  input  wire logic [NUM_CH-1:0] chan,
  input  wire logic [15:0]       start,
  input  wire logic [15:0]       count,
  input  wire logic [7:0]        byte_idx,
  output logic      [7:0]        packed_byte
);
  if (NUM_CH < 1 || NUM_CH > 2000) begin : g_bad_width
    $error("bit_packer: NUM_CH must lie in 1..2000");
  end

  always_comb begin
    int pos;
    pos         = 0;
    packed_byte = 8'h00;
    for (int j = 0; j < 8; j++) begin
      pos = 8 * int'(byte_idx) + j;
      // bits past the requested count pad with zero
      if (pos < int'(count) && int'(start) + pos < NUM_CH) begin
        packed_byte[j] = chan[int'(start) + pos];
      end
    end
  end
endmodule

// File: hdl/modbus_tcp_frame_server.sv
// modbus/tcp query server: parses a frame, checks it, streams the answer
`timescale 1ns/1ps
`include "mbt_consts.svh"
module modbus_tcp_frame_server
  import mbt_pkg::*;
#(
  parameter int NUM_CH = 16
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        station_address,
  input  wire logic [NUM_CH-1:0] output_readback,
  input  wire logic [NUM_CH-1:0] input_channel,
  input  wire logic              rx_valid,
  input  wire logic [7:0]        rx_data,
  input  wire logic              rx_last,
  output logic                   rx_ready,
  output logic                   tx_valid,
  output logic [7:0]             tx_data,
  output logic                   tx_last,
  input  wire logic              tx_ready,
  output logic                   write_strobe,
  output logic [7:0]             write_func,
  output logic [15:0]            write_addr,
  output logic [15:0]            write_value,
  output logic                   frame_dropped
);
  if (NUM_CH < 1 || NUM_CH > 2000) begin : g_bad_width
    $error("modbus_tcp_frame_server: NUM_CH must lie in 1..2000");
  end

  query_if q ();

  srv_state_t        state;
  resp_kind_t        kind;
  logic [7:0]        exc;
  logic [15:0]       trans_id;
  logic [15:0]       proto_id;
  logic [7:0]        unit;
  logic [7:0]        func;
  logic [15:0]       word_a;
  logic [15:0]       word_b;
  logic [7:0]        rlen;
  logic [7:0]        nbytes;
  logic [8:0]        idx;
  logic [8:0]        last_idx;
  logic [NUM_CH-1:0] snap;

  resp_kind_t        next_kind;
  logic [7:0]        next_exc;
  logic [7:0]        next_nbytes;
  logic [7:0]        next_rlen;
  logic              next_addressed;
  logic              next_bcast;
  logic              next_write;
  logic [16:0]       span;
  logic [15:0]       bit_bytes;

  logic [8:0]        sel;
  logic [8:0]        body_pos;
  logic [8:0]        bits_pos;
  logic [7:0]        packed_byte;
  logic [7:0]        func_out;
  logic [7:0]        next_tx;
  logic              take;

  frame_parser u_parser (
    .clk      (clk),
    .rst_n    (rst_n),
    .rx_valid (rx_valid),
    .rx_data  (rx_data),
    .rx_last  (rx_last),
    .rx_ready (rx_ready),
    .q        (q.parser)
  );

  // a new query is only looked at while no answer is in flight
  assign q.accept = (state == ST_IDLE);
  assign take     = q.valid && (state == ST_IDLE);

  // classify the waiting query
  always_comb begin
    span           = {1'b0, q.word_a} + {1'b0, q.word_b};
    bit_bytes      = (q.word_b + 16'h0007) >> 3;
    next_kind      = RK_EXC;
    next_exc       = `EXC_FUNC;
    next_nbytes    = 8'h00;
    next_rlen      = 8'h03;
    next_bcast     = (q.unit == `BCAST_ADDR);
    next_addressed = q.frame_ok && (q.unit <= `MAX_STATION)
                     && (next_bcast || q.unit == station_address);
    next_write     = 1'b0;
    case (q.func)
      `FC_READ_OUT, `FC_READ_IN: begin
        next_exc = `EXC_VALUE;
        if (q.plen != `FIXED_PLEN || q.word_b == 16'h0000) begin
          next_kind = RK_EXC;
        end else if (span > 17'(NUM_CH)) begin
          next_exc = `EXC_ADDR;
        end else begin
          next_kind   = RK_BITS;
          next_nbytes = bit_bytes[7:0];
          next_rlen   = 8'h03 + bit_bytes[7:0];
        end
      end
      `FC_READ_HOLD, `FC_READ_INREG: begin
        next_exc = `EXC_VALUE;
        if (q.plen == `FIXED_PLEN && q.word_b != 16'h0000 && q.word_b <= `MAX_REGS) begin
          next_kind   = RK_REGS;
          next_nbytes = {q.word_b[6:0], 1'b0};
          next_rlen   = 8'h03 + {q.word_b[6:0], 1'b0};
        end
      end
      `FC_WRITE_ONE: begin
        next_exc = `EXC_VALUE;
        if (q.plen == `FIXED_PLEN && (q.word_b == `COIL_ON || q.word_b == `COIL_OFF)) begin
          next_kind  = RK_ECHO;
          next_rlen  = 8'h06;
          next_write = 1'b1;
        end
      end
      `FC_WRITE_REG: begin
        next_exc = `EXC_VALUE;
        if (q.plen == `FIXED_PLEN) begin
          next_kind  = RK_ECHO;
          next_rlen  = 8'h06;
          next_write = 1'b1;
        end
      end
      `FC_WRITE_OUTS, `FC_WRITE_REGS: begin
        next_exc = `EXC_VALUE;
        if (q.plen >= `MULTI_PLEN) begin
          next_kind  = RK_ECHO;
          next_rlen  = 8'h06;
          next_write = 1'b1;
        end
      end
      default: begin
        next_kind = RK_EXC;
        next_exc  = `EXC_FUNC;
      end
    endcase
  end

  // latch the query so the parser can take the next frame early
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      kind     <= RK_EXC;
      exc      <= 8'h00;
      trans_id <= 16'h0000;
      proto_id <= 16'h0000;
      unit     <= 8'h00;
      func     <= 8'h00;
      word_a   <= 16'h0000;
      word_b   <= 16'h0000;
      rlen     <= 8'h00;
      nbytes   <= 8'h00;
      last_idx <= 9'h000;
    end else if (take) begin
      kind     <= next_kind;
      exc      <= next_exc;
      trans_id <= q.trans_id;
      proto_id <= q.proto_id;
      unit     <= q.unit;
      func     <= q.func;
      word_a   <= q.word_a;
      word_b   <= q.word_b;
      rlen     <= next_rlen;
      nbytes   <= next_nbytes;
      last_idx <= `HDR_LEN - 9'h001 + {1'b0, next_rlen};
    end
  end

  // one snapshot per query keeps all data bytes of an answer consistent
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      snap <= '0;
    end else if (take) begin
      snap <= (q.func == `FC_READ_OUT) ? output_readback : input_channel;
    end
  end

  // write requests are passed on, broadcast included; multi-write data is not forwarded
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      write_strobe  <= 1'b0;
      write_func    <= 8'h00;
      write_addr    <= 16'h0000;
      write_value   <= 16'h0000;
      frame_dropped <= 1'b0;
    end else begin
      write_strobe  <= take && next_addressed && next_write;
      frame_dropped <= take && !next_addressed;
      if (take && next_addressed && next_write) begin
        write_func  <= q.func;
        write_addr  <= q.word_a;
        write_value <= q.word_b;
      end
    end
  end

  // answer byte generator, indexed over the whole frame
  assign sel      = idx + 9'h001;
  assign body_pos = sel - 9'h008;
  assign bits_pos = sel - `POS_BITS_DATA;
  assign func_out = (kind == RK_EXC) ? (func | `ERR_BIT) : func;

  bit_packer #(
    .NUM_CH (NUM_CH)
  ) u_packer (
    .chan        (snap),
    .start       (word_a),
    .count       (word_b),
    .byte_idx    (bits_pos[7:0]),
    .packed_byte (packed_byte)
  );

  always_comb begin
    next_tx = 8'h00;
    case (sel)
      `POS_TID_HI: next_tx = trans_id[15:8];
      `POS_TID_LO: next_tx = trans_id[7:0];
      `POS_PID_HI: next_tx = proto_id[15:8];
      `POS_PID_LO: next_tx = proto_id[7:0];
      `POS_LEN_HI: next_tx = `LEN_HI;
      `POS_LEN_LO: next_tx = rlen;
      `POS_UNIT:   next_tx = unit;
      `POS_FUNC:   next_tx = func_out;
      default: begin
        case (kind)
          RK_EXC:  next_tx = exc;
          RK_ECHO: begin
            // address then value or count, each high byte first
            case (body_pos[1:0])
              2'h0:    next_tx = word_a[15:8];
              2'h1:    next_tx = word_a[7:0];
              2'h2:    next_tx = word_b[15:8];
              default: next_tx = word_b[7:0];
            endcase
          end
          RK_BITS: next_tx = (body_pos == 9'h000) ? nbytes : packed_byte;
          // no register map behind this block: register words read as zero,
          // so word and byte order of 16 and 32 bit values cannot show here
          RK_REGS: next_tx = (body_pos == 9'h000) ? nbytes : 8'h00;
          default: next_tx = 8'h00;
        endcase
      end
    endcase
  end

  // answer stream; nothing leaves unless a query was taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      tx_last  <= 1'b0;
      idx      <= 9'h000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take && next_addressed && !next_bcast) begin
            state    <= ST_SEND;
            tx_valid <= 1'b1;
            tx_data  <= q.trans_id[15:8];
            tx_last  <= 1'b0;
            idx      <= 9'h000;
          end
        end
        ST_SEND: begin
          if (tx_ready) begin
            if (idx == last_idx) begin
              state    <= ST_IDLE;
              tx_valid <= 1'b0;
              tx_last  <= 1'b0;
            end else begin
              idx     <= sel;
              tx_data <= next_tx;
              tx_last <= (sel == last_idx);
            end
          end
        end
        default: begin
          state    <= ST_IDLE;
          tx_valid <= 1'b0;
          tx_last  <= 1'b0;
        end
      endcase
    end
  end
endmodule

// File: verification/modbus_tcp_frame_server_props.sv
// port assertions for the modbus/tcp frame server
`timescale 1ns/1ps
module frame_server_props #(
  parameter int NUM_CH = 16
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] station_address,
  input wire logic       rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic       rx_last,
  input wire logic       rx_ready,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_last,
  input wire logic       tx_ready,
  input wire logic       write_strobe,
  input wire logic [7:0] write_func,
  input wire logic       frame_dropped
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [8:0]  rx_pos;
  logic [8:0]  tx_pos;
  logic [7:0]  st [0:7];
  logic [23:0] pend;
  logic [23:0] cur;
  logic [7:0]  len;
  wire         rx_take = rx_valid && rx_ready;
  wire         tx_take = tx_valid && tx_ready;
  always_ff @(posedge clk) begin
    if (!rst_n) rx_pos <= 9'h000;
    else if (rx_take) rx_pos <= rx_last ? 9'h000 : rx_pos + 9'h001;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) tx_pos <= 9'h000;
    else if (tx_take) tx_pos <= tx_last ? 9'h000 : tx_pos + 9'h001;
  end
  // staged copy: a new query may arrive while the previous answer still streams
  always_ff @(posedge clk) begin
    if (rx_take && rx_pos < 9'h008) st[rx_pos[2:0]] <= rx_data;
    if (rx_take && rx_last) pend <= {st[0], st[1], st[7]};
    if (tx_take && tx_pos == 9'h000) cur <= pend;
    if (tx_take && tx_pos == 9'h005) len <= tx_data;
  end
  sequence s_ans_start;
    $rose(tx_valid);
  endsequence
  sequence s_bcast_end;
    rx_take && rx_last && st[6] == 8'h00 && !tx_valid;
  endsequence
  chk_hold_stall: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("answer byte changed in stall");
  chk_only_answers: assert property (s_ans_start |-> $past(!rx_ready))
    else $error("answer began with no query pending");
  chk_bcast_silent: assert property (s_bcast_end |=> !tx_valid [*8])
    else $error("broadcast query was answered");
  chk_tid_high: assert property (tx_valid && tx_pos == 9'h000 |-> tx_data == pend[23:16])
    else $error("transaction id high byte not copied");
  chk_tid_low: assert property (tx_valid && tx_pos == 9'h001 |-> tx_data == cur[15:8])
    else $error("transaction id low byte not copied");
  chk_prefix_zero: assert property (tx_valid && tx_pos inside {[2:4]} |-> tx_data == 8'h00)
    else $error("protocol id or length high not zero");
  chk_station_echo: assert property (tx_valid && tx_pos == 9'h006 |->
    tx_data == station_address) else $error("answer station byte wrong");
  chk_length_count: assert property (tx_take && tx_last |-> tx_pos == {1'b0, len} + 9'h005)
    else $error("length field disagrees with answer size");
  chk_func_echo: assert property (tx_valid && tx_pos == 9'h007 && len != 8'h03 |->
    tx_data == cur[7:0]) else $error("normal answer function code differs");
  chk_func_error: assert property (tx_valid && tx_pos == 9'h007 && len == 8'h03 |->
    tx_data == (cur[7:0] | 8'h80)) else $error("error answer lacks top bit");
  chk_strobe_write: assert property (write_strobe |->
    write_func inside {8'h05, 8'h06, 8'h0F, 8'h10} ##1 !write_strobe)
    else $error("write strobe wrong");
  chk_drop_pulse: assert property (frame_dropped |=> !frame_dropped)
    else $error("drop flag longer than a cycle");
endmodule
bind modbus_tcp_frame_server frame_server_props #(.NUM_CH(NUM_CH)) i_frame_server_props (
  .clk(clk), .rst_n(rst_n), .station_address(station_address), .rx_valid(rx_valid),
  .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .write_strobe(write_strobe),
  .write_func(write_func), .frame_dropped(frame_dropped));

// File: verification/mbt_master_model.sv
// master side model: streams queued query bytes, collects answer bytes
`timescale 1ns/1ps
module mbt_master_model (
  input  wire logic       clk,
  input  wire logic       rx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  input  wire logic       slow,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_last,
  output logic            tx_ready
);
  logic [8:0] q[$];
  logic [7:0] got[$];
  int         n_last = 0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    tx_ready = 1'b1;
  end
  // a byte leaves the queue only at the edge that takes it
  always @(posedge clk) begin
    if (rx_valid && rx_ready) void'(q.pop_front());
    if (tx_valid && tx_ready) got.push_back(tx_data);
    if (tx_valid && tx_ready && tx_last) n_last++;
  end
  // idle data toggles so a stale byte can never look valid
  always @(negedge clk) begin
    tx_ready <= !slow || !tx_ready;
    rx_valid <= q.size() > 0;
    rx_data <= (q.size() > 0) ? q[0][7:0] : ~rx_data;
    rx_last <= (q.size() > 0) && q[0][8];
  end
endmodule

// File: verification/modbus_tcp_frame_server_tb.sv
// self-checking bench for the modbus/tcp frame server
`timescale 1ns/1ps
module modbus_tcp_frame_server_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  station_address = 8'h01;
  logic [15:0] output_readback = 16'hA5C3;
  logic [15:0] input_channel = 16'h3E91;
  logic        slow = 1'b1;
  logic        rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
  logic [7:0]  rx_data, tx_data, write_func;
  logic [15:0] write_addr, write_value;
  logic        write_strobe, frame_dropped;
  int          n_fail = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          n_wr = 0;
  int          n_drop = 0;
  int          n_ans = 0;
  logic [7:0]  body[$];
  modbus_tcp_frame_server i_modbus_tcp_frame_server (.clk(clk), .rst_n(rst_n),
    .station_address(station_address), .output_readback(output_readback),
    .input_channel(input_channel), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .write_strobe(write_strobe), .write_func(write_func),
    .write_addr(write_addr), .write_value(write_value), .frame_dropped(frame_dropped));
  mbt_master_model i_mbt_master_model (.clk(clk), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .slow(slow), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .tx_ready(tx_ready));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (write_strobe === 1'b1) n_wr++;
    if (frame_dropped === 1'b1) n_drop++;
    if (cycles == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // bad: 1 protocol id, 2 length high, 3 length low off by one
  task automatic send(input logic [15:0] tid, input logic [7:0] unit, input logic [7:0] fc,
                      input logic [15:0] a, input logic [15:0] b, input int nx, input int bad);
    logic [7:0] f[$];
    f = {tid[15:8], tid[7:0], 8'h00, 8'(bad == 1), 8'(bad == 2), 8'(6 + nx + (bad == 3)),
         unit, fc, a[15:8], a[7:0], b[15:8], b[7:0]};
    for (int i = 0; i < nx; i++) f.push_back(i == 0 ? 8'(nx - 1) : 8'hA0 + 8'(i));
    foreach (f[i]) i_mbt_master_model.q.push_back({i == f.size() - 1, f[i]});
  endtask
  task automatic expect_ans(input logic [15:0] tid, input logic [7:0] unit, input logic [7:0] fc);
    logic [7:0] e[$];
    e = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'(body.size() + 2), unit, fc};
    e = {e, body};
    n_ans++;
    for (int k = 0; k < 2000 && i_mbt_master_model.n_last < n_ans; k++) @(negedge clk);
    chk("answers", 16'(n_ans), 16'(i_mbt_master_model.n_last));
    foreach (e[k]) chk("answer byte", {8'h00, e[k]}, {8'h00,
      i_mbt_master_model.got.size() > 0 ? i_mbt_master_model.got.pop_front() : 8'hXX});
  endtask
  task automatic bits(input logic [15:0] ch, input int st, input int cnt);
    logic [7:0] v;
    body = {8'((cnt + 7) / 8)};
    for (int k = 0; k < (cnt + 7) / 8; k++) begin
      v = 8'h00;
      for (int j = 0; j < 8; j++) if (8 * k + j < cnt) v[j] = ch[st + 8 * k + j];
      body.push_back(v);
    end
  endtask
  // two queries back to back into a slow sink
  task automatic s_read_out();
    send(16'h0102, 8'h01, 8'h01, 16'h0000, 16'h0002, 0, 0);
    send(16'h3C5A, 8'h01, 8'h01, 16'h0003, 16'h000D, 0, 0);
    bits(output_readback, 0, 2);
    expect_ans(16'h0102, 8'h01, 8'h01);
    bits(output_readback, 3, 13);
    expect_ans(16'h3C5A, 8'h01, 8'h01);
  endtask
  task automatic s_read_in_err();
    send(16'h0201, 8'h01, 8'h02, 16'h0005, 16'h000B, 0, 0);
    bits(input_channel, 5, 11);
    expect_ans(16'h0201, 8'h01, 8'h02);
    send(16'h0202, 8'h01, 8'h02, 16'h0000, 16'h0000, 0, 0);
    body = {8'h03};
    expect_ans(16'h0202, 8'h01, 8'h82);
    send(16'h0203, 8'h01, 8'h01, 16'h000F, 16'h0002, 0, 0);
    body = {8'h02};
    expect_ans(16'h0203, 8'h01, 8'h81);
    send(16'h0204, 8'h01, 8'h07, 16'h0000, 16'h0001, 0, 0);
    body = {8'h01};
    expect_ans(16'h0204, 8'h01, 8'h87);
  endtask
  task automatic s_regs();
    send(16'h0301, 8'h01, 8'h03, 16'h0000, 16'h0002, 0, 0);
    body = {8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
    expect_ans(16'h0301, 8'h01, 8'h03);
    send(16'h0302, 8'h01, 8'h04, 16'h0001, 16'h0001, 0, 0);
    body = {8'h02, 8'h00, 8'h00};
    expect_ans(16'h0302, 8'h01, 8'h04);
    send(16'h0303, 8'h01, 8'h03, 16'h0000, 16'h007E, 0, 0);
    body = {8'h03};
    expect_ans(16'h0303, 8'h01, 8'h83);
  endtask
  task automatic s_writes();
    logic [7:0]  fc[4] = '{8'h05, 8'h06, 8'h0F, 8'h10};
    logic [15:0] a[4] = '{16'h0003, 16'h0011, 16'h0002, 16'h0004};
    logic [15:0] b[4] = '{16'hFF00, 16'h1234, 16'h000A, 16'h0002};
    int          nx[4] = '{0, 0, 3, 5};
    int          w;
    for (int i = 0; i < 4; i++) begin
      w = n_wr;
      send(16'h0400 + 16'(i), 8'h01, fc[i], a[i], b[i], nx[i], 0);
      body = {a[i][15:8], a[i][7:0], b[i][15:8], b[i][7:0]};
      expect_ans(16'h0400 + 16'(i), 8'h01, fc[i]);
      chk("strobes", 16'(w + 1), 16'(n_wr));
      chk("write func", {8'h00, fc[i]}, {8'h00, write_func});
      chk("write addr", a[i], write_addr);
      chk("write value", b[i], write_value);
    end
    // a coil value other than on or off, and a multi write with no data, are refused
    w = n_wr;
    send(16'h0404, 8'h01, 8'h05, 16'h0003, 16'h1234, 0, 0);
    body = {8'h03};
    expect_ans(16'h0404, 8'h01, 8'h85);
    send(16'h0405, 8'h01, 8'h10, 16'h0004, 16'h0002, 0, 0);
    expect_ans(16'h0405, 8'h01, 8'h90);
    chk("refused strobes", 16'(w), 16'(n_wr));
  endtask
  // malformed and foreign frames, a broadcast, then the top unit address
  task automatic s_drop();
    int d;
    int w;
    d = n_drop;
    w = n_wr;
    station_address = 8'hF7;
    for (int i = 1; i < 4; i++) send(16'h0500, 8'hF7, 8'h01, 16'h0000, 16'h0001, 0, i);
    send(16'h0504, 8'h05, 8'h01, 16'h0000, 16'h0001, 0, 0);
    send(16'h0505, 8'hF8, 8'h01, 16'h0000, 16'h0001, 0, 0);
    send(16'h0506, 8'h00, 8'h05, 16'h0001, 16'hFF00, 0, 0);
    send(16'h7E01, 8'hF7, 8'h01, 16'h0008, 16'h0008, 0, 0);
    bits(output_readback, 8, 8);
    expect_ans(16'h7E01, 8'hF7, 8'h01);
    chk("drops", 16'(d + 5), 16'(n_drop));
    chk("broadcast write", 16'(w + 1), 16'(n_wr));
    chk("stray bytes", 16'h0000, 16'(i_mbt_master_model.got.size()));
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    s_read_out();
    slow = 1'b0;
    s_read_in_err();
    s_regs();
    s_writes();
    s_drop();
    wrap_up();
  end
endmodule
